/* src/vip_pkg.sv */
// constants of the vectored interrupt priority block: offsets, vectors, resets
// assumes one core clock, synchronous active-high reset, AXI4-Lite register access
// Contract
// - nmi accepted while disabled, outside priority control, ranked above all
// - nmi occurrence raises standby release
// - in nmi mode watchdog overflow is sole nmi, vector 0004H
// - in interval mode watchdog overflow is maskable priority 0, same vector
// - mask flag gates each maskable request; priority flag picks group
// - high-group request may interrupt low-group servicing
// - ties within a group resolved by default order, 0 highest, 22 lowest
// - maskable request generation raises standby release; code raises it only for sources whose mask flag is 0
// - maskable set holds seven external and fifteen internal sources
// - break instruction vectors to 003EH, accepted while disabled, no priority control
// - twenty-four sources in total across all kinds
// - each maskable source own vector; priority 1 at 0006H, 3 at 000AH
// - pin edge sources priorities 6 to 8, vectors 0010H 0012H 0014H
// - can sources priorities 9 to 12, vectors 0016H to 001CH step two
// - uart sources priorities 14 to 16, vectors 0020H 0022H 0024H
// - watch 20,21 at 002EH,0030H; serial b 22 at 0032H
// - request flag set on request, cleared on acknowledge or reset
// - mask 0 enables, 1 disables; masks reset to all ones
package vip_pkg;
    localparam int          NUM_MASKABLE  = 23;
    localparam logic [31:0] NUM_EXTERNAL  = 32'h7;
    localparam logic [31:0] NUM_INTERNAL  = 32'hf;
    localparam logic [31:0] NUM_SOURCES   = 32'h18;

    // register byte offsets
    localparam logic [7:0]  OFF_REQ_FLAGS = 8'h00;
    localparam logic [7:0]  OFF_MASK      = 8'h04;
    localparam logic [7:0]  OFF_PRIORITY  = 8'h08;
    localparam logic [7:0]  OFF_CTRL      = 8'h0c;
    localparam logic [7:0]  OFF_PRESENT   = 8'h10;
    localparam logic [7:0]  OFF_EVT_STAT  = 8'h14;
    localparam logic [7:0]  OFF_EVT_CLR   = 8'h18;
    localparam logic [7:0]  OFF_EVT_EN    = 8'h1c;

    // reset values
    localparam logic [22:0] RST_REQ_FLAGS = 23'h000000;
    localparam logic [22:0] RST_MASK      = 23'h7fffff;
    localparam logic [22:0] RST_PRIORITY  = 23'h7fffff;
    localparam logic [2:0]  RST_EVT       = 3'h0;

    // field positions
    localparam int          CTRL_NMI_MODE = 0;
    localparam int          FLAG_NMI_POS  = 23;
    localparam int          PRES_KIND_LO  = 16;
    localparam int          PRES_VALID    = 31;
    localparam int          EVT_NMI       = 0;
    localparam int          EVT_BREAK     = 1;
    localparam int          EVT_MASKABLE  = 2;

    // vectors
    localparam logic [15:0] VEC_BASE      = 16'h0004;
    localparam logic [15:0] VEC_BREAK     = 16'h003e;
    localparam logic [4:0]  VEC_GAP_IDX   = 5'h14;

    typedef enum logic [1:0] {
        VIP_KIND_MASKABLE = 2'h0,
        VIP_KIND_NMI      = 2'h1,
        VIP_KIND_BREAK    = 2'h2
    } vip_kind_t;

    typedef enum logic [1:0] {
        VIP_RESP_OKAY   = 2'h0,
        VIP_RESP_SLVERR = 2'h2
    } vip_resp_t;
endpackage : vip_pkg

/* src/vip_top.sv */
// vectored interrupt priority block: request flags, masks, groups, vector out
// assumes events are one-cycle pulses from logic on the same clock
`timescale 1ns/100ps
`default_nettype none
module vip_top (
    // clock and reset
    input  wire logic                 clock,
    input  wire logic                 rst,
    // request sources, index equals default priority
    input  wire logic [22:0]          source_event,
    input  wire logic                 watchdog_overflow_request,
    input  wire logic                 software_break_instruction,
    // processor core
    input  wire logic                 core_int_enable,
    input  wire logic                 core_serving_low,
    input  wire logic                 core_ack,
    output logic                      irq_request_q,
    output logic [15:0]               irq_vector_q,
    output vip_pkg::vip_kind_t        irq_kind_q,
    output logic                      irq_high_group_q,
    output logic                      standby_release_q,
    output logic                      irq_line,
    // axi4-lite write address and data
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    // axi4-lite write response
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    output logic [1:0]                s_axi_bresp,
    // axi4-lite read
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    input  wire logic [7:0]           s_axi_araddr,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp
);
    import vip_pkg::*;

    // lowest set index wins, so index 0 is the highest default order
    function automatic logic [4:0] first_set(input logic [22:0] v);
        logic [4:0] idx;
        idx = 5'h0;
        for (int i = NUM_MASKABLE - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = i[4:0];
            end
        end
        return idx;
    endfunction : first_set

    // two bytes per vector; one slot skipped before the watch sources
    function automatic logic [15:0] maskable_vector(input logic [4:0] idx);
        logic [15:0] v;
        v = VEC_BASE + {10'h0, idx, 1'b0};
        if (idx >= VEC_GAP_IDX) begin
            v = v + 16'h0002;
        end
        return v;
    endfunction : maskable_vector

    // byte-lane merge for writable registers
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    logic [22:0] req_flags_q;
    logic [22:0] mask_q;
    logic [22:0] prio_q;
    logic        nmi_mode_q;
    logic        nmi_pending_q;
    logic        brk_pending_q;
    logic [4:0]  sel_idx_q;
    logic [2:0]  evt_stat_q;
    logic [2:0]  evt_en_q;

    // write channel holding state
    logic        aw_held_q;
    logic        w_held_q;
    logic [7:0]  aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        wr_fire;
    logic        rd_fire;
    logic        wr_mapped;
    logic        wr_ro;

    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
    assign wr_fire       = aw_held_q && w_held_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_fire       = s_axi_arvalid && s_axi_arready;

    logic wr_flags;
    logic wr_mask;
    logic wr_prio;
    logic wr_ctrl;
    logic wr_evt_clr;
    logic wr_evt_en;
    assign wr_flags   = wr_fire && aw_addr_q == OFF_REQ_FLAGS;
    assign wr_mask    = wr_fire && aw_addr_q == OFF_MASK;
    assign wr_prio    = wr_fire && aw_addr_q == OFF_PRIORITY;
    assign wr_ctrl    = wr_fire && aw_addr_q == OFF_CTRL;
    assign wr_evt_clr = wr_fire && aw_addr_q == OFF_EVT_CLR;
    assign wr_evt_en  = wr_fire && aw_addr_q == OFF_EVT_EN;
    assign wr_ro      = aw_addr_q == OFF_PRESENT || aw_addr_q == OFF_EVT_STAT;
    assign wr_mapped  = wr_flags || wr_mask || wr_prio || wr_ctrl || wr_evt_clr || wr_evt_en
                        || wr_ro;

    logic [31:0] wr_word_flags;
    logic [31:0] wr_word_mask;
    logic [31:0] wr_word_prio;
    logic [31:0] wr_word_ctrl;
    logic [31:0] wr_word_en;
    assign wr_word_flags = merge({9'h0, req_flags_q}, w_data_q, w_strb_q);
    assign wr_word_mask  = merge({9'h0, mask_q}, w_data_q, w_strb_q);
    assign wr_word_prio  = merge({9'h0, prio_q}, w_data_q, w_strb_q);
    assign wr_word_ctrl  = merge({31'h0, nmi_mode_q}, w_data_q, w_strb_q);
    assign wr_word_en    = merge({29'h0, evt_en_q}, w_data_q, w_strb_q);

    always_ff @(posedge clock) begin
        if (rst) begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            aw_addr_q    <= 8'h00;
            w_data_q     <= 32'h0;
            w_strb_q     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= VIP_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_mapped && !wr_ro) ? VIP_RESP_OKAY : VIP_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // watchdog overflow routes to nmi or to maskable slot 0 by mode
    logic        wdt_nmi_evt;
    logic [22:0] set_vec;
    assign wdt_nmi_evt = watchdog_overflow_request && nmi_mode_q;
    assign set_vec     = source_event
                         | {22'h0, watchdog_overflow_request && !nmi_mode_q};

    // acknowledge clears what is being presented this cycle
    logic        ack_nmi;
    logic        ack_brk;
    logic [22:0] ack_vec;
    assign ack_nmi = core_ack && irq_request_q && irq_kind_q == VIP_KIND_NMI;
    assign ack_brk = core_ack && irq_request_q && irq_kind_q == VIP_KIND_BREAK;
    assign ack_vec = (core_ack && irq_request_q && irq_kind_q == VIP_KIND_MASKABLE)
                     ? (23'h1 << sel_idx_q) : 23'h0;

    // a new request beats both a software write of zero and an acknowledge
    always_ff @(posedge clock) begin
        if (rst) begin
            req_flags_q <= RST_REQ_FLAGS;
        end else if (wr_flags) begin
            // a write racing an acknowledge must not revive the served flag
            req_flags_q <= (wr_word_flags[22:0] & ~ack_vec) | set_vec;
        end else begin
            req_flags_q <= (req_flags_q & ~ack_vec) | set_vec;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            nmi_pending_q <= 1'b0;
            brk_pending_q <= 1'b0;
        end else begin
            nmi_pending_q <= (nmi_pending_q && !ack_nmi) || wdt_nmi_evt;
            brk_pending_q <= (brk_pending_q && !ack_brk) || software_break_instruction;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            mask_q     <= RST_MASK;
            prio_q     <= RST_PRIORITY;
            nmi_mode_q <= 1'b0;
            evt_en_q   <= RST_EVT;
        end else begin
            if (wr_mask) begin
                mask_q <= wr_word_mask[22:0];
            end
            if (wr_prio) begin
                prio_q <= wr_word_prio[22:0];
            end
            if (wr_ctrl) begin
                nmi_mode_q <= wr_word_ctrl[CTRL_NMI_MODE];
            end
            if (wr_evt_en) begin
                evt_en_q <= wr_word_en[2:0];
            end
        end
    end

    // selection from flags with the current acknowledge already removed
    logic [22:0] live;
    logic [22:0] eligible;
    logic [22:0] high_set;
    logic        any_high;
    logic        any_mask;
    logic [4:0]  win_idx;
    logic        nmi_live;
    logic        brk_live;
    assign live     = req_flags_q & ~ack_vec;
    assign eligible = live & ~mask_q & {NUM_MASKABLE{core_int_enable}};
    assign high_set = eligible & ~prio_q;
    assign any_high = |high_set;
    // while a low request is served only the high group may nest in
    assign any_mask = core_serving_low ? any_high : |eligible;
    assign win_idx  = any_high ? first_set(high_set) : first_set(eligible);
    assign nmi_live = nmi_pending_q && !ack_nmi;
    assign brk_live = brk_pending_q && !ack_brk;

    always_ff @(posedge clock) begin
        if (rst) begin
            irq_request_q    <= 1'b0;
            irq_vector_q     <= 16'h0;
            irq_kind_q       <= VIP_KIND_MASKABLE;
            irq_high_group_q <= 1'b0;
            sel_idx_q        <= 5'h0;
        end else begin
            irq_request_q    <= nmi_live || brk_live || any_mask;
            irq_high_group_q <= 1'b0;
            sel_idx_q        <= win_idx;
            // nmi ignores enable and groups and outranks everything
            if (nmi_live) begin
                irq_kind_q   <= VIP_KIND_NMI;
                irq_vector_q <= VEC_BASE;
            end else if (brk_live) begin
                irq_kind_q   <= VIP_KIND_BREAK;
                irq_vector_q <= VEC_BREAK;
            end else begin
                irq_kind_q       <= VIP_KIND_MASKABLE;
                irq_vector_q     <= maskable_vector(win_idx);
                irq_high_group_q <= any_high;
            end
        end
    end

    // wakes the core even with interrupts disabled, as long as unmasked
    always_ff @(posedge clock) begin
        if (rst) begin
            standby_release_q <= 1'b0;
        end else begin
            standby_release_q <= wdt_nmi_evt
                                 || |(set_vec & ~mask_q);
        end
    end

    // software-visible event log driving the single interrupt line
    logic [2:0] evt_set;
    logic [2:0] evt_clr;
    // bit positions shared with software through the package
    always_comb begin
        evt_set               = 3'h0;
        evt_set[EVT_NMI]      = ack_nmi;
        evt_set[EVT_BREAK]    = ack_brk;
        evt_set[EVT_MASKABLE] = |ack_vec;
    end
    assign evt_clr = wr_evt_clr ? w_data_q[2:0] & {3{w_strb_q[0]}} : 3'h0;

    always_ff @(posedge clock) begin
        if (rst) begin
            evt_stat_q <= RST_EVT;
        end else begin
            evt_stat_q <= (evt_stat_q & ~evt_clr) | evt_set;
        end
    end

    assign irq_line = |(evt_stat_q & evt_en_q);

    // read channel
    logic [31:0] rd_word;
    logic        rd_hit;
    always_comb begin
        rd_word = 32'h0;
        rd_hit  = 1'b1;
        case (s_axi_araddr)
            OFF_REQ_FLAGS: begin
                rd_word[22:0]         = req_flags_q;
                rd_word[FLAG_NMI_POS] = nmi_pending_q;
            end
            OFF_MASK:      rd_word = {9'h0, mask_q};
            OFF_PRIORITY:  rd_word = {9'h0, prio_q};
            OFF_CTRL:      rd_word = {31'h0, nmi_mode_q};
            OFF_PRESENT: begin
                // live view of what the core is being offered right now
                rd_word[15:0]              = irq_vector_q;
                rd_word[PRES_KIND_LO +: 2] = irq_kind_q;
                rd_word[PRES_VALID]        = irq_request_q;
            end
            OFF_EVT_STAT:  rd_word = {29'h0, evt_stat_q};
            OFF_EVT_CLR:   rd_word = 32'h0;
            OFF_EVT_EN:    rd_word = {29'h0, evt_en_q};
            default:       rd_hit  = 1'b0;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= VIP_RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? VIP_RESP_OKAY : VIP_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule : vip_top
`default_nettype wire

/* verification/vip_top_asserts.sv */
// checker of the vectored interrupt block, top module ports only
// assumes one clock domain, synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module vip_top_asserts (
    // clock and reset
    input wire logic               clock,
    input wire logic               rst,
    // core side inputs
    input wire logic               software_break_instruction,
    input wire logic               core_int_enable,
    input wire logic               core_serving_low,
    input wire logic               core_ack,
    // core side outputs
    input wire logic               irq_request_q,
    input wire logic [15:0]        irq_vector_q,
    input wire vip_pkg::vip_kind_t irq_kind_q,
    input wire logic               irq_high_group_q,
    input wire logic               standby_release_q
);
    import vip_pkg::*;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    a_nmi_vector: assert property (
        irq_request_q && irq_kind_q == VIP_KIND_NMI |-> irq_vector_q == 16'h0004)
        else $error("nmi vector wrong");
    a_break_vector: assert property (
        irq_request_q && irq_kind_q == VIP_KIND_BREAK |-> irq_vector_q == 16'h003e)
        else $error("break vector wrong");
    a_break_taken: assert property (
        software_break_instruction |-> ##2 irq_request_q)
        else $error("break not presented");
    a_nmi_standby: assert property (
        $rose(irq_kind_q == VIP_KIND_NMI) |-> $past(standby_release_q))
        else $error("nmi without standby release");
    a_acked_leaves: assert property (
        core_ack && irq_request_q && irq_kind_q != VIP_KIND_MASKABLE
        |=> !irq_request_q || irq_kind_q != $past(irq_kind_q))
        else $error("acked request still shown");
    a_vec_table: assert property (
        irq_request_q && irq_kind_q == VIP_KIND_MASKABLE
        |-> !irq_vector_q[0] && irq_vector_q inside {[16'h4:16'h2a], [16'h2e:16'h32]})
        else $error("maskable vector off table");
    a_low_serving: assert property (
        $rose(irq_request_q) && irq_kind_q == VIP_KIND_MASKABLE && $past(core_serving_low)
        |-> irq_high_group_q)
        else $error("low group shown while serving low");
    a_enable_gate: assert property (
        $rose(irq_request_q) && irq_kind_q == VIP_KIND_MASKABLE |-> $past(core_int_enable))
        else $error("maskable shown while disabled");
endmodule : vip_top_asserts

bind vip_top vip_top_asserts chk_u (.*);
`default_nettype wire

/* verification/vip_core_model.sv */
// processor core stand-in: acknowledges each presented request after a wait
// assumes irq outputs registered on the same rising edge
`timescale 1ns/100ps
`default_nettype none
module vip_core_model (
    // clock and reset
    input  wire logic               clock,
    input  wire logic               rst,
    // request from the block
    input  wire logic               irq_request_q,
    input  wire logic [15:0]        irq_vector_q,
    input  wire vip_pkg::vip_kind_t irq_kind_q,
    input  wire logic [3:0]         ack_delay,
    // acknowledge and what it took
    output logic                    core_ack,
    output logic                    ack_fire,
    output logic [15:0]             ack_vec,
    output logic [1:0]              ack_kind
);
    import vip_pkg::*;
    logic [3:0] wait_q;

    // one ack per request; a wait exercises slow service
    always_ff @(posedge clock) begin
        ack_fire <= 1'b0;
        if (rst) begin
            core_ack <= 1'b0;
            wait_q   <= 4'h0;
        end else if (core_ack) begin
            core_ack <= 1'b0;
            wait_q   <= 4'h0;
            ack_fire <= irq_request_q;
            ack_vec  <= irq_vector_q;
            ack_kind <= irq_kind_q;
        end else if (irq_request_q) begin
            if (wait_q >= ack_delay) core_ack <= 1'b1;
            else wait_q <= wait_q + 4'h1;
        end
    end
endmodule : vip_core_model
`default_nettype wire

/* verification/vip_top_bench.sv */
// self-checking bench of the vectored interrupt block with a core stand-in
// assumes the block answers on one 100 MHz clock
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module vip_top_bench;
    import vip_pkg::*;
    logic clock, rst = 1'b1, watchdog_overflow_request = 1'b0;
    logic software_break_instruction = 1'b0, core_int_enable = 1'b1, core_serving_low = 1'b0;
    logic [22:0] source_event = 23'h0;
    logic core_ack, irq_request_q, irq_high_group_q, standby_release_q, irq_line, ack_fire;
    logic [15:0] irq_vector_q, ack_vec;
    vip_kind_t irq_kind_q;
    logic [1:0] ack_kind, s_axi_bresp, s_axi_rresp;
    logic [3:0] dly = 4'h0, s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [17:0] exp_q[$];
    int err_count = 0, checked = 0;

    vip_top dut_u (.*);
    vip_core_model core_u (.clock(clock), .rst(rst), .irq_request_q(irq_request_q),
        .irq_vector_q(irq_vector_q), .irq_kind_q(irq_kind_q), .ack_delay(dly),
        .core_ack(core_ack), .ack_fire(ack_fire), .ack_vec(ack_vec), .ack_kind(ack_kind));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // expected {kind, vector}; slot 20 onward skips one word
    function automatic logic [17:0] exp_of(input int k, input int i);
        int v;
        v = (k == 1) ? 'h4 : (k == 2) ? 'h3e : (i < 20) ? 'h4 + 2 * i : 'h6 + 2 * i;
        return {k[1:0], v[15:0]};
    endfunction : exp_of

    // every acknowledge must match the oldest expectation
    always @(posedge clock) begin
        if (ack_fire) begin
            if (exp_q.size() == 0) `CHK(1'b0, 1'b1)
            else `CHK({ack_kind, ack_vec}, exp_q.pop_front())
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        // one edge apart, so no strobe is assigned twice in a step
        @(posedge clock);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr  <= a;
        s_axi_wvalid  <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge clock);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 50);
        s_axi_bready <= 1'b0;
        `CHK({s_axi_bvalid, s_axi_bresp}, {1'b1, er})
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clock);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr  <= a;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge clock);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 50);
        s_axi_rready <= 1'b0;
        `CHK({s_axi_rvalid, s_axi_rresp, s_axi_rdata}, {1'b1, er, ed})
    endtask : rd

    task automatic pulse(input logic [22:0] s, input logic w, input logic b);
        @(posedge clock);
        source_event               <= s;
        watchdog_overflow_request  <= w;
        software_break_instruction <= b;
        @(posedge clock);
        source_event               <= 23'h0;
        watchdog_overflow_request  <= 1'b0;
        software_break_instruction <= 1'b0;
    endtask : pulse

    task automatic drain();
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 300) begin
            @(posedge clock);
            n++;
        end
        repeat (6) @(posedge clock);
        `CHK(exp_q.size(), 0)
    endtask : drain

    task automatic end_sim();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim

    initial begin
        logic [22:0] pr, m;
        void'($urandom(94));
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        rd(OFF_MASK, 32'h7fffff, 2'h0);
        rd(OFF_PRIORITY, 32'h7fffff, 2'h0);
        rd(OFF_REQ_FLAGS, 32'h0, 2'h0);
        rd(8'h20, 32'h0, 2'h2);
        pulse(23'h20, 1'b0, 1'b0);
        @(posedge clock);
        `CHK(standby_release_q, 1'b0)
        repeat (3) @(posedge clock);
        rd(OFF_REQ_FLAGS, 32'h20, 2'h0);
        wr(OFF_REQ_FLAGS, 32'h0, 2'h0);
        $display("test reset and mask done");
        pr = 23'($urandom);
        wr(OFF_PRIORITY, {9'h0, pr}, 2'h0);
        wr(OFF_MASK, 32'h0, 2'h0);
        for (int i = 0; i < 23; i++) begin
            dly <= 4'($urandom % 6);
            exp_q.push_back(exp_of(0, i));
            pulse(23'h1 << i, 1'b0, 1'b0);
            @(posedge clock);
            `CHK(standby_release_q, 1'b1)
            drain();
        end
        m = 23'($urandom) | 23'h1;
        for (int g = 0; g < 2; g++)
            for (int i = 0; i < 23; i++)
                if (m[i] && pr[i] == g[0]) exp_q.push_back(exp_of(0, i));
        pulse(m, 1'b0, 1'b0);
        drain();
        $display("test vectors and order done");
        core_int_enable <= 1'b0;
        wr(OFF_CTRL, 32'h1, 2'h0);
        exp_q.push_back(exp_of(1, 0));
        exp_q.push_back(exp_of(2, 0));
        pulse(23'h2, 1'b1, 1'b1);
        drain();
        exp_q.push_back(exp_of(0, 1));
        core_int_enable <= 1'b1;
        drain();
        wr(OFF_CTRL, 32'h0, 2'h0);
        wr(OFF_MASK, 32'h1, 2'h0);
        pulse(23'h0, 1'b1, 1'b0);
        repeat (4) @(posedge clock);
        rd(OFF_REQ_FLAGS, 32'h1, 2'h0);
        exp_q.push_back(exp_of(0, 0));
        wr(OFF_MASK, 32'h0, 2'h0);
        drain();
        $display("test nmi break watchdog done");
        wr(OFF_PRIORITY, 32'h7ffffe, 2'h0);
        core_serving_low <= 1'b1;
        pulse(23'h4, 1'b0, 1'b0);
        repeat (6) @(posedge clock);
        exp_q.push_back(exp_of(0, 0));
        pulse(23'h1, 1'b0, 1'b0);
        drain();
        exp_q.push_back(exp_of(0, 2));
        core_serving_low <= 1'b0;
        drain();
        $display("test nesting done");
        rd(OFF_EVT_STAT, 32'h7, 2'h0);
        wr(OFF_EVT_EN, 32'h7, 2'h0);
        @(posedge clock);
        `CHK(irq_line, 1'b1)
        wr(OFF_EVT_CLR, 32'h1, 2'h0);
        rd(OFF_EVT_STAT, 32'h6, 2'h0);
        wr(OFF_EVT_EN, 32'h1, 2'h0);
        @(posedge clock);
        `CHK(irq_line, 1'b0)
        wr(OFF_EVT_CLR, 32'h6, 2'h0);
        wr(OFF_EVT_STAT, 32'h0, 2'h2);
        rd(OFF_EVT_STAT, 32'h0, 2'h0);
        $display("test event interrupt done");
        end_sim();
    end

    initial begin
        #400000;
        err_count++;
        end_sim();
    end
endmodule : vip_top_bench
`default_nettype wire
